// File: include/timer8_pkg.sv
/*
 * Constants and carrier types shared by the 8-bit timer waveform control block.
 * Assumes the compiler reads it before any file that imports it.
 */
package timer8_pkg;

    // register byte addresses on the APB slave
    localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
    localparam logic [7:0] ADDR_COUNT   = 8'h08;
    localparam logic [7:0] ADDR_CMP_A   = 8'h0c;
    localparam logic [7:0] ADDR_CMP_B   = 8'h10;
    localparam logic [7:0] ADDR_FLAGS   = 8'h14;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h18;

    // timer_control_a fields
    localparam int CTRL_A_OUT_A_HI = 7;
    localparam int CTRL_A_OUT_A_LO = 6;
    localparam int CTRL_A_OUT_B_HI = 5;
    localparam int CTRL_A_OUT_B_LO = 4;
    localparam int CTRL_A_WAVE_HI  = 1;
    localparam int CTRL_A_WAVE_LO  = 0;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;

    // timer_control_b, flag and pin direction fields
    localparam int CTRL_B_WAVE_HIGH = 3;
    localparam int FLAG_MATCH_A     = 0;
    localparam int FLAG_OVERFLOW    = 1;
    localparam int FLAG_MATCH_B     = 2;
    localparam int DIR_BIT_A        = 0;
    localparam int DIR_BIT_B        = 1;

    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] COUNT_MAX    = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_STEP   = 8'h01;

    // waveform_select encodings
    localparam logic [2:0] WAVE_NORMAL   = 3'h0;
    localparam logic [2:0] WAVE_PHASE_FF = 3'h1;
    localparam logic [2:0] WAVE_CLEAR_A  = 3'h2;
    localparam logic [2:0] WAVE_FAST_FF  = 3'h3;
    localparam logic [2:0] WAVE_PHASE_A  = 3'h5;
    localparam logic [2:0] WAVE_FAST_A   = 3'h7;

    // compare output mode codes
    localparam logic [1:0] OUT_OFF    = 2'h0;
    localparam logic [1:0] OUT_TOGGLE = 2'h1;
    localparam logic [1:0] OUT_CLEAR  = 2'h2;
    localparam logic [1:0] OUT_SET    = 2'h3;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } count_dir_type;

    // per-channel view of one counter step
    typedef struct packed {
        logic tick;
        logic match;
        logic at_top;
        logic cmp_is_top;
        logic down;
        logic pwm;
        logic phase;
        logic wave_high;
    } wave_event_type;

endpackage : timer8_pkg

// File: logic/compare_output_unit.sv
/*
 * One compare output: turns match and TOP events into the output level.
 * Assumes the parent qualifies every event with the timer tick.
 */
`timescale 1ns/10ps
module compare_output_unit #(
    parameter bit TOGGLE_IN_PWM = 1'b1
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [1:0]                out_code,
    input  wire timer8_pkg::wave_event_type ev,
    output logic                           out_r
);
    import timer8_pkg::*;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 1'b0;
        end else if (ev.tick) begin
            if (!ev.pwm) begin
                if (ev.match) begin
                    case (out_code)
                        OUT_TOGGLE: out_r <= ~out_r;
                        OUT_CLEAR:  out_r <= 1'b0;
                        OUT_SET:    out_r <= 1'b1;
                        default:    out_r <= out_r;
                    endcase
                end
            end else if (out_code == OUT_TOGGLE) begin
                // channel b has no pwm toggle: code is reserved there
                if (ev.match && ev.wave_high && TOGGLE_IN_PWM) begin
                    out_r <= ~out_r;
                end
            end else if (out_code[1]) begin
                if (ev.match && !ev.cmp_is_top) begin
                    // up-count or fast match: clear for 10, set for 11
                    out_r <= (out_code == OUT_SET) ^ ev.down;
                end else if (ev.at_top && (ev.cmp_is_top || !ev.phase)) begin
                    out_r <= (out_code == OUT_CLEAR);
                end
            end
        end
    end

    property p_nonpwm_set;
        @(posedge clk) disable iff (!rst_n)
        ev.tick && !ev.pwm && ev.match && out_code == OUT_SET |=> out_r;
    endproperty
    a_nonpwm_set: assert property (p_nonpwm_set) else $error("set on match missed");

    property p_pwm_top_clear;
        @(posedge clk) disable iff (!rst_n)
        ev.tick && ev.pwm && !ev.phase && ev.at_top && out_code == OUT_SET
            |=> !out_r;
    endproperty
    a_pwm_top_clear: assert property (p_pwm_top_clear) else $error("clear at top missed");

endmodule : compare_output_unit

// File: logic/timer8_waveform_control.sv
/*
 * 8-bit timer with waveform modes, two compare outputs and an APB register slave.
 * Assumes timer_tick is a one-cycle enable from an outside prescaler, synchronous to pclk.
 */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Operation
// - counter runs on pclk; timer tick enables every step and every flag set
// - nonzero channel a output mode takes the pin; driver needs direction bit
// - non-pwm channel a codes: off, toggle, clear, set on match
// - fast pwm a: 10 clear on match set at top, 11 opposite, 01 toggle if high
// - phase pwm a: 10 clear up match set down match, 11 reverse, 01 toggle if high
// - pwm a: compare equal top with high bit set acts at top only
// - nonzero channel b output mode takes the pin; driver needs direction bit
// - non-pwm channel b codes: off, toggle, clear, set on match
// - fast pwm b: 01 reserved, 10 clear match set top, 11 reverse
// - phase pwm b: 01 reserved, 10 clear up set down, 11 reverse
// - pwm b: compare equal top with high bit set acts at top only
// - control a bits 3 and 2 are read-only zero
// - three-bit mode selects count sequence and top source
// - compare writes immediate in modes 0 and 2, buffered to top in pwm
// - overflow at max in 0,2,3; bottom in 1,5; top in 7
// - clear-on-match and fast mode 7 flag match a, clear counter next tick
// - fast pwm counts up to top then clears to bottom next tick
// - phase pwm counts up, turns at top without a hold, counts down, repeats
// - waveform high bit lives in control b bit 3, joins control a 1:0
module timer8_waveform_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              timer_tick,
    output logic                   compare_out_a,
    output logic                   compare_out_b,
    output logic                   override_a,
    output logic                   override_b,
    output logic                   pin_a_oe_n,
    output logic                   pin_b_oe_n
);
    import timer8_pkg::*;

    logic [7:0]     ctrl_a_r;
    logic           wave_high_r;
    logic [7:0]     cnt_r;
    logic [7:0]     buf_a_r;
    logic [7:0]     buf_b_r;
    logic [7:0]     act_a_r;
    logic [7:0]     act_b_r;
    logic           flag_a_r;
    logic           flag_b_r;
    logic           ovf_r;
    logic           block_r;
    logic           dir_a_r;
    logic           dir_b_r;
    count_dir_type  dir_r;
    logic [31:0]    prdata_r;
    logic           pready_r;
    logic           pslverr_r;
    logic           override_a_r;
    logic           override_b_r;
    logic           pin_a_oe_n_r;
    logic           pin_b_oe_n_r;

    logic [7:0]     addr;
    logic [2:0]     wave_sel;
    logic           phase;
    logic           fast;
    logic           pwm;
    logic           top_from_a;
    logic [7:0]     cmp_a;
    logic [7:0]     cmp_b;
    logic [7:0]     top;
    logic           setup;
    logic           wr_en;
    logic           cnt_wr;
    logic           flag_wr;
    logic           at_top;
    logic           match_a;
    logic           match_b;
    logic           ovf_hit;
    logic [31:0]    rd_data;
    logic           rd_mapped;
    logic [1:0]     out_code [0:1];
    wave_event_type ev [0:1];
    logic [1:0]     out_pin;

    assign addr    = paddr[7:0];
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready_r && pwrite;
    assign cnt_wr  = wr_en && addr == ADDR_COUNT;
    assign flag_wr = wr_en && addr == ADDR_FLAGS;

    // mode decode
    assign wave_sel   = {wave_high_r, ctrl_a_r[CTRL_A_WAVE_HI:CTRL_A_WAVE_LO]};
    assign phase      = wave_sel == WAVE_PHASE_FF || wave_sel == WAVE_PHASE_A;
    assign fast       = wave_sel == WAVE_FAST_FF || wave_sel == WAVE_FAST_A;
    assign pwm        = phase || fast;
    assign top_from_a = wave_sel == WAVE_CLEAR_A || wave_sel == WAVE_PHASE_A
                        || wave_sel == WAVE_FAST_A;

    // non-pwm modes see the written value at once
    assign cmp_a  = pwm ? act_a_r : buf_a_r;
    assign cmp_b  = pwm ? act_b_r : buf_b_r;
    assign top    = top_from_a ? cmp_a : COUNT_MAX;
    assign at_top = timer_tick && cnt_r == top;

    // a counter write suppresses the compare on the following tick
    assign match_a = timer_tick && !block_r && cnt_r == cmp_a;
    assign match_b = timer_tick && !block_r && cnt_r == cmp_b;

    always_comb begin
        ovf_hit = 1'b0;
        if (timer_tick) begin
            if (phase) begin
                ovf_hit = cnt_r == COUNT_BOTTOM;
            end else if (wave_sel == WAVE_FAST_A) begin
                ovf_hit = cnt_r == top;
            end else begin
                ovf_hit = cnt_r == COUNT_MAX;
            end
        end
    end

    // counter and direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= RESET_BYTE;
            dir_r <= DIR_UP;
        end else if (cnt_wr) begin
            cnt_r <= pwdata[7:0];
        end else if (timer_tick) begin
            if (phase) begin
                if (dir_r == DIR_UP) begin
                    if (cnt_r == top) begin
                        dir_r <= DIR_DOWN;
                        cnt_r <= cnt_r - COUNT_STEP;
                    end else begin
                        cnt_r <= cnt_r + COUNT_STEP;
                    end
                end else if (cnt_r == COUNT_BOTTOM) begin
                    dir_r <= DIR_UP;
                    cnt_r <= cnt_r + COUNT_STEP;
                end else begin
                    cnt_r <= cnt_r - COUNT_STEP;
                end
            end else begin
                dir_r <= DIR_UP;
                if ((top_from_a || fast) && cnt_r == top) begin
                    cnt_r <= COUNT_BOTTOM;
                end else begin
                    cnt_r <= cnt_r + COUNT_STEP;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_r <= 1'b0;
        end else if (cnt_wr) begin
            block_r <= 1'b1;
        end else if (timer_tick) begin
            block_r <= 1'b0;
        end
    end

    // compare values: written buffer and active copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_a_r <= RESET_BYTE;
            buf_b_r <= RESET_BYTE;
        end else if (wr_en && addr == ADDR_CMP_A) begin
            buf_a_r <= pwdata[7:0];
        end else if (wr_en && addr == ADDR_CMP_B) begin
            buf_b_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_a_r <= RESET_BYTE;
            act_b_r <= RESET_BYTE;
        end else if (!pwm || at_top) begin
            act_a_r <= buf_a_r;
            act_b_r <= buf_b_r;
        end
    end

    // flags: write one clears, a same-cycle event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
            ovf_r    <= 1'b0;
        end else begin
            flag_a_r <= match_a || (flag_a_r && !(flag_wr && pwdata[FLAG_MATCH_A]));
            flag_b_r <= match_b || (flag_b_r && !(flag_wr && pwdata[FLAG_MATCH_B]));
            ovf_r    <= ovf_hit || (ovf_r && !(flag_wr && pwdata[FLAG_OVERFLOW]));
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_a_r    <= RESET_BYTE;
            wave_high_r <= 1'b0;
            dir_a_r     <= 1'b0;
            dir_b_r     <= 1'b0;
        end else if (wr_en && addr == ADDR_CTRL_A) begin
            ctrl_a_r <= pwdata[7:0] & CTRL_A_WMASK;
        end else if (wr_en && addr == ADDR_CTRL_B) begin
            wave_high_r <= pwdata[CTRL_B_WAVE_HIGH];
        end else if (wr_en && addr == ADDR_PIN_DIR) begin
            dir_a_r <= pwdata[DIR_BIT_A];
            dir_b_r <= pwdata[DIR_BIT_B];
        end
    end

    // read mux
    always_comb begin
        rd_data   = 32'h0000_0000;
        rd_mapped = 1'b1;
        if (addr == ADDR_CTRL_A) begin
            rd_data[7:0] = ctrl_a_r;
        end else if (addr == ADDR_CTRL_B) begin
            rd_data[CTRL_B_WAVE_HIGH] = wave_high_r;
        end else if (addr == ADDR_COUNT) begin
            rd_data[7:0] = cnt_r;
        end else if (addr == ADDR_CMP_A) begin
            rd_data[7:0] = buf_a_r;
        end else if (addr == ADDR_CMP_B) begin
            rd_data[7:0] = buf_b_r;
        end else if (addr == ADDR_FLAGS) begin
            rd_data[FLAG_MATCH_A]  = flag_a_r;
            rd_data[FLAG_OVERFLOW] = ovf_r;
            rd_data[FLAG_MATCH_B]  = flag_b_r;
        end else if (addr == ADDR_PIN_DIR) begin
            rd_data[DIR_BIT_A] = dir_a_r;
            rd_data[DIR_BIT_B] = dir_b_r;
        end else begin
            rd_mapped = 1'b0;
        end
    end

    // zero wait states: read data is caught in the setup cycle, so a
    // counter read may be one pclk old by the end of the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup && !pready_r;
            pslverr_r <= setup && !pready_r && !rd_mapped;
            if (setup && !pwrite) begin
                prdata_r <= rd_data;
            end
        end
    end

    // pin control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            override_a_r <= 1'b0;
            override_b_r <= 1'b0;
            pin_a_oe_n_r <= 1'b1;
            pin_b_oe_n_r <= 1'b1;
        end else begin
            override_a_r <= |ctrl_a_r[CTRL_A_OUT_A_HI:CTRL_A_OUT_A_LO];
            override_b_r <= |ctrl_a_r[CTRL_A_OUT_B_HI:CTRL_A_OUT_B_LO];
            pin_a_oe_n_r <= !(|ctrl_a_r[CTRL_A_OUT_A_HI:CTRL_A_OUT_A_LO] && dir_a_r);
            pin_b_oe_n_r <= !(|ctrl_a_r[CTRL_A_OUT_B_HI:CTRL_A_OUT_B_LO] && dir_b_r);
        end
    end

    assign out_code[0] = ctrl_a_r[CTRL_A_OUT_A_HI:CTRL_A_OUT_A_LO];
    assign out_code[1] = ctrl_a_r[CTRL_A_OUT_B_HI:CTRL_A_OUT_B_LO];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_chan
            assign ev[g] = '{
                tick:       timer_tick,
                match:      g == 0 ? match_a : match_b,
                at_top:     at_top,
                cmp_is_top: out_code[g][1] && ((g == 0 ? cmp_a : cmp_b) == top),
                down:       dir_r == DIR_DOWN,
                pwm:        pwm,
                phase:      phase,
                wave_high:  wave_high_r
            };
            compare_output_unit #(
                .TOGGLE_IN_PWM (g == 0)
            ) u_out (
                .clk      (pclk),
                .rst_n    (presetn),
                .out_code (out_code[g]),
                .ev       (ev[g]),
                .out_r    (out_pin[g])
            );
        end
    endgenerate

    assign compare_out_a = out_pin[0];
    assign compare_out_b = out_pin[1];
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;
    assign override_a    = override_a_r;
    assign override_b    = override_b_r;
    assign pin_a_oe_n    = pin_a_oe_n_r;
    assign pin_b_oe_n    = pin_b_oe_n_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_idle_hold;
        !timer_tick && !cnt_wr |=> $stable(cnt_r);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("counter moved without tick");

    property p_oe_a;
        |ctrl_a_r[CTRL_A_OUT_A_HI:CTRL_A_OUT_A_LO] && dir_a_r |=> !pin_a_oe_n && override_a;
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("channel a driver not enabled");

    property p_oe_b;
        !dir_b_r |=> pin_b_oe_n;
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("channel b driven without direction");

    property p_ro_bits;
        setup && !pwrite && addr == ADDR_CTRL_A |=> pready && prdata[3:2] == 2'b00;
    endproperty
    a_ro_bits: assert property (p_ro_bits) else $error("reserved control bits not zero");

    property p_buffered;
        pwm && !at_top |=> $stable(act_a_r) && $stable(act_b_r);
    endproperty
    a_buffered: assert property (p_buffered) else $error("compare updated away from top");

    property p_count_step;
        timer_tick && wave_sel == WAVE_NORMAL && !cnt_wr |=> cnt_r == $past(cnt_r) + COUNT_STEP;
    endproperty
    a_count_step: assert property (p_count_step) else $error("normal step wrong");

    property p_ovf_phase;
        timer_tick && phase && cnt_r == COUNT_BOTTOM |=> ovf_r;
    endproperty
    a_ovf_phase: assert property (p_ovf_phase) else $error("overflow missed at bottom");

    sequence s_top_a_match;
        timer_tick && top_from_a && !phase && cnt_r == cmp_a && !block_r && !cnt_wr;
    endsequence
    property p_top_a_clear;
        s_top_a_match |=> flag_a_r && cnt_r == COUNT_BOTTOM;
    endproperty
    a_top_a_clear: assert property (p_top_a_clear) else $error("match a did not clear counter");

    property p_fast_wrap;
        timer_tick && fast && cnt_r == top && !cnt_wr |=> cnt_r == COUNT_BOTTOM;
    endproperty
    a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not wrap");

    sequence s_phase_peak;
        timer_tick && phase && dir_r == DIR_UP && cnt_r == top && top != COUNT_BOTTOM
            && !cnt_wr;
    endsequence
    property p_phase_turn;
        s_phase_peak |=> dir_r == DIR_DOWN && cnt_r != $past(cnt_r);
    endproperty
    a_phase_turn: assert property (p_phase_turn) else $error("phase pwm did not turn");

    property p_match_b;
        timer_tick && !block_r && cnt_r == cmp_b |=> flag_b_r;
    endproperty
    a_match_b: assert property (p_match_b) else $error("match b flag missed");

endmodule : timer8_waveform_control

// File: verification/tb_timer8_waveform_control.sv
/*
 * Self-checking bench for the 8-bit timer waveform control block.
 * Assumes the timer8_pkg package is compiled first and that the block answers on APB.
 */
`timescale 1ns/10ps
module tb_timer8_waveform_control;
    import timer8_pkg::*;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } row_type;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        timer_tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        compare_out_a;
    logic        compare_out_b;
    logic        override_a;
    logic        override_b;
    logic        pin_a_oe_n;
    logic        pin_b_oe_n;
    logic [31:0] rd_data;
    logic        rd_err;
    int          failures;
    int          cmp_count;
    row_type     rows [6];

    timer8_waveform_control u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .compare_out_a(compare_out_a), .compare_out_b(compare_out_b),
        .override_a(override_a), .override_b(override_b), .pin_a_oe_n(pin_a_oe_n),
        .pin_b_oe_n(pin_b_oe_n)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    // request held until pready is seen high; the bench timeout is the only other exit
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string msg);
        apb(a, 1'b0, 32'h0);
        check(rd_data, e, msg);
    endtask : rd

    // one-cycle tick pulses with a gap; ends mid-cycle so outputs have settled
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            timer_tick <= 1'b1;
            @(posedge pclk);
            timer_tick <= 1'b0;
        end
        @(negedge pclk);
    endtask : tick

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    initial begin
        #200us;
        failures++;
        $display("mismatch at %0t: timeout", $time);
        print_verdict();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timer_tick = 1'b0;
        rows = '{'{ADDR_CTRL_A, 32'hffffffff, 32'hf3}, '{ADDR_CTRL_B, 32'hff, 32'h08},
                 '{ADDR_CMP_A, 32'h5a, 32'h5a}, '{ADDR_CMP_B, 32'ha5, 32'ha5},
                 '{ADDR_PIN_DIR, 32'h03, 32'h03}, '{ADDR_COUNT, 32'h77, 32'h77}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check({30'h0, pin_a_oe_n, pin_b_oe_n}, 32'h3, "oe in reset");
        rd(ADDR_CTRL_A, 32'h0, "ctrl a reset");
        rd(ADDR_FLAGS, 32'h0, "flags reset");
        rd(8'h1c, 32'h0, "unmapped data");
        check({31'h0, rd_err}, 32'h1, "unmapped err");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e, "register row");
        end
        // clear-on-match with toggle on channel a
        wr(ADDR_CTRL_B, 32'h0);
        wr(ADDR_CTRL_A, 32'h42);
        wr(ADDR_CMP_A, 32'h05);
        wr(ADDR_COUNT, 32'h0);
        wr(ADDR_FLAGS, 32'h07);
        @(negedge pclk);
        check({override_a, pin_a_oe_n, override_b, pin_b_oe_n}, 32'h9, "pin owner");
        tick(6);
        check({31'h0, compare_out_a}, 32'h1, "match toggle on");
        rd(ADDR_COUNT, 32'h0, "match clear");
        rd(ADDR_FLAGS, 32'h01, "match flag");
        tick(6);
        check({31'h0, compare_out_a}, 32'h0, "match toggle off");
        // normal mode: overflow at max, channel b set on match
        wr(ADDR_CTRL_A, 32'h30);
        wr(ADDR_CMP_B, 32'hff);
        wr(ADDR_COUNT, 32'hfe);
        wr(ADDR_FLAGS, 32'h07);
        tick(2);
        check({30'h0, override_b, compare_out_b}, 32'h3, "normal set b");
        rd(ADDR_FLAGS, 32'h06, "normal flags");
        rd(ADDR_COUNT, 32'h0, "normal wrap");
        // fast pwm, top 0xff, new compare values wait for top
        wr(ADDR_CTRL_A, 32'ha3);
        wr(ADDR_CMP_A, 32'h10);
        wr(ADDR_CMP_B, 32'h08);
        wr(ADDR_COUNT, 32'hfd);
        tick(3);
        check({30'h0, compare_out_a, compare_out_b}, 32'h3, "fast set at top");
        rd(ADDR_COUNT, 32'h0, "fast wrap");
        tick(9);
        check({30'h0, compare_out_a, compare_out_b}, 32'h2, "fast clear b");
        tick(8);
        check({31'h0, compare_out_a}, 32'h0, "fast clear a");
        rd(ADDR_COUNT, 32'h11, "fast count");
        wr(ADDR_FLAGS, 32'h07);
        wr(ADDR_CMP_A, 32'h20);
        tick(16);
        rd(ADDR_FLAGS, 32'h00, "fast buffered");
        // phase correct, top 0xff
        wr(ADDR_CTRL_A, 32'h81);
        wr(ADDR_COUNT, 32'hfd);
        tick(3);
        rd(ADDR_COUNT, 32'hfe, "phase turn");
        wr(ADDR_FLAGS, 32'h07);
        tick(8'hdf);
        check({31'h0, compare_out_a}, 32'h1, "phase down set");
        rd(ADDR_COUNT, 32'h1f, "phase down");
        tick(8'h20);
        rd(ADDR_FLAGS, 32'h07, "phase bottom");
        rd(ADDR_COUNT, 32'h01, "phase up again");
        // fast pwm with top from compare a; channel a toggles on the top match
        wr(ADDR_CTRL_A, 32'h43);
        wr(ADDR_CTRL_B, 32'h08);
        wr(ADDR_COUNT, 32'h1e);
        wr(ADDR_FLAGS, 32'h07);
        tick(3);
        check({31'h0, compare_out_a}, 32'h0, "fast toggle a");
        rd(ADDR_COUNT, 32'h0, "top a wrap");
        rd(ADDR_FLAGS, 32'h03, "top a flags");
        // mid-run reset returns pins and registers to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check({30'h0, override_a, pin_a_oe_n}, 32'h1, "pins in reset");
        @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_CTRL_B, 32'h0, "ctrl b after reset");
        rd(ADDR_CTRL_A, 32'h0, "ctrl a after reset");
        print_verdict();
    end
endmodule : tb_timer8_waveform_control
